/* File: hdl/lfs_fault_supervisor.sv */
/*
 * Two-channel fault supervisor of a buck LED driver: gates switching,
 * forces switch states, discharges the loop filter, times restarts and
 * drives the open-drain fault flags.
 * Assumes comparator inputs synchronous to sys_clk and a power-on reset.
 */
// Notes on behaviour
// RULE1 - Input undervoltage stops that channel's switching; recovery restarts it.
// RULE2 - Bootstrap undervoltage: high side off, low side on until recovered.
// RULE3 - Loop filter overvoltage pulls the fault flag low (open load).
// RULE4 - Low output sense node pulls the channel fault flag low (short).
// RULE5 - A short is only reported; switching and regulation carry on.
// RULE6 - High-side overcurrent: high side off, filter discharged, low side on.
// RULE7 - Low-side overcurrent: both switches off, loop filter discharged.
// RULE8 - Either overcurrent starts a 3.6 ms timer; expiry restarts it.
// RULE9 - Thermal restart waits until temperature fell 10 degC below trip.
// RULE10 - Every automatic restart except bootstrap recovery runs soft-start before full switching.
// RULE11 - Fault flag goes low only for open load or output short.
// RULE12 - The host pulls each flag up to 5 V through a resistor.
// RULE13 - Undervoltage, bootstrap and thermal faults use no timer, no flag.
// RULE14 - Dropout and bias undervoltage are diagnostics: no timer, no flag.
// RULE15 - Open load keeps switching at near full duty until flagged.
// RULE16 - Over-temperature forces that channel alone into shutdown.
// RULE17 - Dropout disconnects the error amplifier until the input recovers.
// RULE18 - The flag is released once open load or short is gone.
// RULE19 - Each channel has its own timer, state and flag.
module lfs_fault_supervisor #(
    parameter int unsigned RESTART_CYCLES = lfs_pkg::RESTART_DELAY_CYCLES
) (
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire lfs_pkg::lfs_sense_t [1:0]       channel_sense,
    input  wire logic                            analog_bias_undervoltage,
    output lfs_pkg::lfs_drive_t [1:0]            channel_drive,
    output logic [1:0]                           channel_fault_flag_n_out,
    output logic [1:0]                           channel_fault_flag_n_oe,
    output logic [1:0]                           input_dropout_diag,
    output logic                                 analog_bias_undervoltage_diag
);

    localparam logic [lfs_pkg::SOFT_W-1:0] SOFT_LAST =
        lfs_pkg::SOFT_W'(lfs_pkg::SOFT_START_CYCLES - 1);

    lfs_pkg::lfs_state_t                state_reg   [2];
    lfs_pkg::lfs_state_t                state_next  [2];
    logic [lfs_pkg::SOFT_W-1:0]         soft_cnt_reg [2];
    logic [1:0]                         low_side_trip_reg;
    logic [1:0]                         low_side_trip_next;
    lfs_pkg::lfs_drive_t [1:0]          drive_reg;
    lfs_pkg::lfs_drive_t [1:0]          drive_next;
    logic [1:0]                         dropout_reg;
    logic                               bias_uv_reg;
    logic [1:0]                         timer_start;
    logic [1:0]                         timer_clear;
    logic [1:0]                         timer_done;
    logic [1:0]                         flag_report;

    // Diagnostics are passed on for the host; only dropout also steers the error amplifier.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dropout_reg <= '0;
            bias_uv_reg <= 1'b0;
        end else begin
            dropout_reg <= {channel_sense[1].input_dropout,
                            channel_sense[0].input_dropout}; // RULE14
            bias_uv_reg <= analog_bias_undervoltage; // RULE14
        end
    end

    assign input_dropout_diag            = dropout_reg;
    assign analog_bias_undervoltage_diag = bias_uv_reg;
    assign channel_drive                 = drive_reg;

    for (genvar ch = 0; ch < lfs_pkg::CHANNELS; ch++) begin : g_ch

        // Per-channel decode of the comparator inputs.
        wire lfs_pkg::lfs_sense_t s = channel_sense[ch];
        wire hot      = s.thermal_shutdown;
        wire hs_trip  = s.high_side_overcurrent_fault;
        wire ls_trip  = s.low_side_overcurrent_fault;
        wire any_trip = hs_trip || ls_trip;
        wire in_uvlo  = s.input_uvlo;
        wire boot_low = s.bootstrap_undervoltage_fault;
        wire active   = (state_reg[ch] == lfs_pkg::LFS_SOFT) ||
                        (state_reg[ch] == lfs_pkg::LFS_RUN) ||
                        (state_reg[ch] == lfs_pkg::LFS_BOOT_LOW);
        wire soft_done = (state_reg[ch] == lfs_pkg::LFS_SOFT) &&
                         (soft_cnt_reg[ch] == SOFT_LAST);

        // Only an overcurrent trip arms the timer; thermal cancels it.
        assign timer_start[ch] = active && any_trip && !hot; // RULE8 RULE13
        assign timer_clear[ch] = hot; // RULE16
        // Open load and short alone reach the flag, whatever the state.
        assign flag_report[ch] = s.open_load_diagnostic ||
                                 s.output_short_diagnostic; // RULE11 RULE18

        always_comb begin
            state_next[ch]         = state_reg[ch];
            low_side_trip_next[ch] = low_side_trip_reg[ch];
            case (state_reg[ch])
                lfs_pkg::LFS_UVLO: begin
                    if (hot) begin
                        state_next[ch] = lfs_pkg::LFS_THERMAL; // RULE16
                    end else if (!in_uvlo) begin
                        state_next[ch] = lfs_pkg::LFS_SOFT; // RULE1
                    end
                end
                lfs_pkg::LFS_SOFT,
                lfs_pkg::LFS_RUN,
                lfs_pkg::LFS_BOOT_LOW: begin
                    if (hot) begin
                        state_next[ch] = lfs_pkg::LFS_THERMAL; // RULE16
                    end else if (any_trip) begin
                        state_next[ch]         = lfs_pkg::LFS_ILIM_WAIT;
                        low_side_trip_next[ch] = ls_trip; // RULE7
                    end else if (in_uvlo) begin
                        state_next[ch] = lfs_pkg::LFS_UVLO; // RULE1
                    end else if (boot_low) begin
                        state_next[ch] = lfs_pkg::LFS_BOOT_LOW; // RULE2
                    end else if (state_reg[ch] == lfs_pkg::LFS_BOOT_LOW) begin
                        state_next[ch] = lfs_pkg::LFS_RUN; // RULE2
                    end else if (soft_done) begin
                        state_next[ch] = lfs_pkg::LFS_RUN; // RULE10
                    end
                end
                lfs_pkg::LFS_ILIM_WAIT: begin
                    if (hot) begin
                        state_next[ch] = lfs_pkg::LFS_THERMAL; // RULE16
                    end else if (timer_done[ch]) begin
                        state_next[ch] = lfs_pkg::LFS_SOFT; // RULE8 RULE10
                    end
                end
                lfs_pkg::LFS_THERMAL: begin
                    if (!hot) begin
                        state_next[ch] = lfs_pkg::LFS_SOFT; // RULE9 RULE10
                    end
                end
                default: begin
                    state_next[ch] = lfs_pkg::LFS_UVLO;
                end
            endcase
        end

        // Power-stage commands follow the next state so they change
        // together with it.
        always_comb begin
            drive_next[ch] = lfs_pkg::DRIVE_RESET;
            drive_next[ch].error_amp_enable = !s.input_dropout; // RULE17
            case (state_next[ch])
                lfs_pkg::LFS_UVLO: begin
                    drive_next[ch].switch_enable = 1'b0; // RULE1
                end
                lfs_pkg::LFS_SOFT: begin
                    drive_next[ch].switch_enable         = 1'b1; // RULE10
                    drive_next[ch].soft_start            = 1'b1;
                    drive_next[ch].high_side_force_off   = 1'b0;
                    drive_next[ch].low_side_force_off    = 1'b0;
                    drive_next[ch].loop_filter_discharge = 1'b0;
                end
                lfs_pkg::LFS_RUN: begin
                    // Open load and short keep the channel running.
                    drive_next[ch].switch_enable         = 1'b1; // RULE5 RULE15
                    drive_next[ch].high_side_force_off   = 1'b0;
                    drive_next[ch].low_side_force_off    = 1'b0;
                    drive_next[ch].loop_filter_discharge = 1'b0;
                end
                lfs_pkg::LFS_BOOT_LOW: begin
                    drive_next[ch].low_side_force_on     = 1'b1; // RULE2
                    drive_next[ch].low_side_force_off    = 1'b0;
                    drive_next[ch].loop_filter_discharge = 1'b0;
                end
                lfs_pkg::LFS_ILIM_WAIT: begin
                    if (!low_side_trip_next[ch]) begin
                        drive_next[ch].low_side_force_on  = 1'b1; // RULE6
                        drive_next[ch].low_side_force_off = 1'b0;
                    end
                end
                lfs_pkg::LFS_THERMAL: begin
                    drive_next[ch].switch_enable = 1'b0; // RULE16
                end
                default: begin
                    drive_next[ch].switch_enable = 1'b0;
                end
            endcase
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                state_reg[ch]         <= lfs_pkg::LFS_UVLO;
                low_side_trip_reg[ch] <= 1'b0;
                drive_reg[ch]         <= lfs_pkg::DRIVE_RESET;
            end else begin
                state_reg[ch]         <= state_next[ch]; // RULE19
                low_side_trip_reg[ch] <= low_side_trip_next[ch];
                drive_reg[ch]         <= drive_next[ch];
            end
        end

        // Soft-start length counter, running only in the soft-start state.
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                soft_cnt_reg[ch] <= '0;
            end else if (state_reg[ch] == lfs_pkg::LFS_SOFT &&
                         state_next[ch] == lfs_pkg::LFS_SOFT) begin
                soft_cnt_reg[ch] <= soft_cnt_reg[ch] + 1'b1; // RULE10
            end else begin
                soft_cnt_reg[ch] <= '0;
            end
        end

        lfs_restart_timer #(
            .CYCLES (RESTART_CYCLES)
        ) u_timer (
            .sys_clk (sys_clk),
            .rst     (rst),
            .start   (timer_start[ch]),
            .clear   (timer_clear[ch]),
            .busy    (),
            .done    (timer_done[ch])
        ); // RULE8 RULE19

        lfs_flag_driver u_flag (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .report   (flag_report[ch]),
            .flag_out (channel_fault_flag_n_out[ch]),
            .flag_oe  (channel_fault_flag_n_oe[ch])
        ); // RULE3 RULE4 RULE11

    end

endmodule

/* File: hdl/lfs_flag_driver.sv */
/*
 * Open-drain active-low fault flag of one channel.
 * Assumes an external pull-up on the pin; the pin level is resolved
 * outside the design from the enable.
 */
module lfs_flag_driver (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic report,
    output logic      flag_out,
    output logic      flag_oe
);

    logic oe_reg;
    logic out_reg;

    // Pull low while a condition is reported, release otherwise.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oe_reg  <= lfs_pkg::FLAG_OE_RESET;
            out_reg <= lfs_pkg::FLAG_OUT_LEVEL;
        end else begin
            oe_reg  <= report;
            out_reg <= lfs_pkg::FLAG_OUT_LEVEL;
        end
    end

    assign flag_out = out_reg;
    assign flag_oe  = oe_reg;

endmodule

/* File: hdl/lfs_pkg.sv */
/*
 * Shared constants and types of the LED channel fault supervisor.
 * Assumes a single 200 MHz system clock and comparator inputs that are
 * already synchronous to it.
 */
package lfs_pkg;

    localparam int unsigned CHANNELS = 2;

    // System clock rate.
    localparam int unsigned CLK_MHZ = 200;

    // Restart delay after a switch current-limit fault.
    localparam int unsigned RESTART_DELAY_US = 3600;
    localparam int unsigned RESTART_DELAY_CYCLES =
        RESTART_DELAY_US * CLK_MHZ;
    localparam int unsigned TIMER_W = 20;

    // Length of the soft-start phase before full switching.
    localparam int unsigned SOFT_START_US = 10;
    localparam int unsigned SOFT_START_CYCLES = SOFT_START_US * CLK_MHZ;
    localparam int unsigned SOFT_W = 12;

    // Values after reset.
    localparam logic FLAG_OE_RESET  = 1'b0;
    localparam logic FLAG_OUT_LEVEL = 1'b0;

    // Comparator results of one channel, each high while its condition holds.
    // The thermal input already carries the 10 degC trip hysteresis.
    typedef struct packed {
        logic thermal_shutdown;
        logic high_side_overcurrent_fault;
        logic low_side_overcurrent_fault;
        logic input_uvlo;
        logic bootstrap_undervoltage_fault;
        logic input_dropout;
        logic open_load_diagnostic;
        logic output_short_diagnostic;
    } lfs_sense_t;

    // Commands to the power stage of one channel.
    typedef struct packed {
        logic switch_enable;
        logic soft_start;
        logic high_side_force_off;
        logic low_side_force_on;
        logic low_side_force_off;
        logic loop_filter_discharge;
        logic error_amp_enable;
    } lfs_drive_t;

    localparam lfs_drive_t DRIVE_RESET = '{
        switch_enable:         1'b0,
        soft_start:            1'b0,
        high_side_force_off:   1'b1,
        low_side_force_on:     1'b0,
        low_side_force_off:    1'b1,
        loop_filter_discharge: 1'b1,
        error_amp_enable:      1'b0
    };

    typedef enum logic [2:0] {
        LFS_UVLO,
        LFS_SOFT,
        LFS_RUN,
        LFS_BOOT_LOW,
        LFS_ILIM_WAIT,
        LFS_THERMAL
    } lfs_state_t;

endpackage

/* File: hdl/lfs_restart_timer.sv */
/*
 * One-shot restart timer of a single channel.
 * Assumes start is a synchronous single-cycle request and clear a synchronous single-cycle or level one.
 */
module lfs_restart_timer #(
    parameter int unsigned CYCLES = lfs_pkg::RESTART_DELAY_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic clear,
    output logic      busy,
    output logic      done
);

    localparam logic [lfs_pkg::TIMER_W-1:0] LAST =
        lfs_pkg::TIMER_W'(CYCLES - 1);

    logic [lfs_pkg::TIMER_W-1:0] count_reg;
    logic                        busy_reg;
    logic                        done_reg;
    wire                         at_end = busy_reg && (count_reg == LAST);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= at_end && !clear;
            if (clear || at_end) begin
                busy_reg  <= 1'b0;
                count_reg <= '0;
            end else if (start) begin
                busy_reg  <= 1'b1;
                count_reg <= '0;
            end else if (busy_reg) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule

/* File: sim/led_driver_fault_supervisor_bench.sv */
/* Self-checking bench of the fault supervisor with the host flag model.
   Assumes a short restart timer parameter for a brief run. */
module led_driver_fault_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned RC = 20;
    logic                      sys_clk;
    logic                      rst;
    lfs_pkg::lfs_sense_t [1:0] sense;
    logic                      bias_uv;
    lfs_pkg::lfs_drive_t [1:0] drive;
    logic [1:0]                flag_out;
    logic [1:0]                flag_oe;
    logic [1:0]                pin_n;
    logic [1:0]                drop_diag;
    logic                      bias_diag;
    int                        n_fail;
    int                        cmp_count;

    lfs_fault_supervisor #(.RESTART_CYCLES(RC)) DUT (
        .sys_clk(sys_clk), .rst(rst), .channel_sense(sense),
        .analog_bias_undervoltage(bias_uv), .channel_drive(drive),
        .channel_fault_flag_n_out(flag_out),
        .channel_fault_flag_n_oe(flag_oe), .input_dropout_diag(drop_diag),
        .analog_bias_undervoltage_diag(bias_diag));
    lfs_host_model host (.flag_out(flag_out), .flag_oe(flag_oe),
        .flag_pin_n(pin_n));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk_drive(input int ch, input logic [6:0] e);
        check({1'b0, drive[ch]}, {1'b0, e});
    endtask
    task automatic wait_ss(input int ch, input logic v, input int lim);
        int i;
        i = 0;
        while (drive[ch].soft_start !== v && i < lim) begin
            tick(1);
            i++;
        end
        if (drive[ch].soft_start !== v) begin
            n_fail++;
            end_of_test();
        end
    endtask

    task automatic t_start;
        tick(1);
        chk_drive(0, 7'h61);
        chk_drive(1, 7'h61);
        wait_ss(0, 1'b0, 2100);
        chk_drive(0, 7'h41);
        $display("test start done");
    endtask
    task automatic t_ilim;
        for (int k = 0; k < 2; k++) begin
            sense[0].high_side_overcurrent_fault = (k == 0);
            sense[0].low_side_overcurrent_fault = (k == 1);
            tick(1);
            chk_drive(0, (k == 0) ? 7'h1b : 7'h17);
            chk_drive(1, 7'h41);
            check({6'h0, pin_n}, 8'h03);
            sense[0] = '0;
            tick(RC - 3);
            chk_drive(0, (k == 0) ? 7'h1b : 7'h17);
            wait_ss(0, 1'b1, 10);
            chk_drive(0, 7'h61);
            wait_ss(0, 1'b0, 2100);
        end
        $display("test overcurrent done");
    endtask
    task automatic t_flags;
        sense[1].open_load_diagnostic = 1'b1;
        tick(1);
        check({6'h0, pin_n}, 8'h01);
        chk_drive(1, 7'h41);
        sense[1].open_load_diagnostic = 1'b0;
        sense[1].output_short_diagnostic = 1'b1;
        tick(1);
        check({6'h0, pin_n}, 8'h01);
        chk_drive(1, 7'h41);
        sense[1].output_short_diagnostic = 1'b0;
        tick(1);
        check({6'h0, pin_n}, 8'h03);
        $display("test flags done");
    endtask
    task automatic t_uvlo_boot;
        sense[0].input_uvlo = 1'b1;
        tick(1);
        chk_drive(0, 7'h17);
        chk_drive(1, 7'h41);
        sense[0].input_uvlo = 1'b0;
        tick(1);
        chk_drive(0, 7'h61);
        sense[0].bootstrap_undervoltage_fault = 1'b1;
        tick(1);
        chk_drive(0, 7'h19);
        check({6'h0, pin_n}, 8'h03);
        sense[0].bootstrap_undervoltage_fault = 1'b0;
        tick(1);
        chk_drive(0, 7'h41);
        $display("test undervoltage done");
    endtask
    task automatic t_thermal;
        sense[1].thermal_shutdown = 1'b1;
        tick(1);
        chk_drive(1, 7'h17);
        chk_drive(0, 7'h41);
        tick(5);
        chk_drive(1, 7'h17);
        check({6'h0, pin_n}, 8'h03);
        sense[1].thermal_shutdown = 1'b0;
        tick(1);
        chk_drive(1, 7'h61);
        wait_ss(1, 1'b0, 2100);
        $display("test thermal done");
    endtask
    task automatic t_diag;
        sense[0].input_dropout = 1'b1;
        bias_uv = 1'b1;
        tick(1);
        check({5'h0, bias_diag, drop_diag}, 8'h05);
        chk_drive(0, 7'h40);
        check({6'h0, pin_n}, 8'h03);
        sense[0].input_dropout = 1'b0;
        bias_uv = 1'b0;
        tick(1);
        check({5'h0, bias_diag, drop_diag}, 8'h00);
        chk_drive(0, 7'h41);
        $display("test diagnostics done");
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        n_fail = 0;
        cmp_count = 0;
        sense = '0;
        bias_uv = 1'b0;
        rst = 1'b1;
        tick(20);
        chk_drive(0, lfs_pkg::DRIVE_RESET);
        check({6'h0, flag_oe}, 8'h00);
        rst = 1'b0;
        t_start();
        t_ilim();
        t_flags();
        t_uvlo_boot();
        t_thermal();
        t_diag();
        end_of_test();
    end
endmodule

/* File: sim/lfs_fault_supervisor_monitor.sv */
/* Assertion checker of the fault supervisor, bound to its top module.
   Assumes the top module's ports and that channel 0 stands for both. */
module lfs_fault_supervisor_monitor #(
    parameter int unsigned RESTART_CYCLES = 20
) (
    input wire logic                      sys_clk,
    input wire logic                      rst,
    input wire lfs_pkg::lfs_sense_t [1:0] channel_sense,
    input wire logic                      analog_bias_undervoltage,
    input wire lfs_pkg::lfs_drive_t [1:0] channel_drive,
    input wire logic [1:0]                channel_fault_flag_n_out,
    input wire logic [1:0]                channel_fault_flag_n_oe,
    input wire logic [1:0]                input_dropout_diag,
    input wire logic                      analog_bias_undervoltage_diag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire lfs_pkg::lfs_sense_t s0 = channel_sense[0];
    wire lfs_pkg::lfs_drive_t d0 = channel_drive[0];
    wire logic on0 = d0.switch_enable & !s0.thermal_shutdown;
    wire logic trip0 = s0.high_side_overcurrent_fault
        | s0.low_side_overcurrent_fault;
    wire logic [1:0] diag = {
        channel_sense[1].open_load_diagnostic
            | channel_sense[1].output_short_diagnostic,
        s0.open_load_diagnostic | s0.output_short_diagnostic};

    a_hs_trip_off: assert property (
        on0 && !s0.low_side_overcurrent_fault
        && s0.high_side_overcurrent_fault |=> !d0.switch_enable
        && d0.high_side_force_off && d0.low_side_force_on
        && d0.loop_filter_discharge)
        else $error("hs trip action wrong");
    a_ls_trip_off: assert property (
        on0 && s0.low_side_overcurrent_fault
        |=> !d0.switch_enable && d0.high_side_force_off
        && !d0.low_side_force_on && d0.low_side_force_off
        && d0.loop_filter_discharge)
        else $error("ls trip action wrong");
    a_trip_waits: assert property (
        on0 && trip0 |=> !d0.switch_enable [*8])
        else $error("restart came too early");
    a_thermal_off: assert property (
        d0.switch_enable && s0.thermal_shutdown
        |=> !d0.switch_enable && !d0.soft_start && d0.low_side_force_off
        && d0.loop_filter_discharge)
        else $error("thermal did not stop");
    a_uvlo_stop: assert property (
        on0 && !trip0 && s0.input_uvlo
        |=> !d0.switch_enable && !d0.soft_start && d0.high_side_force_off)
        else $error("uvlo did not stop switching");
    a_boot_low: assert property (
        on0 && !trip0 && !s0.input_uvlo
        && s0.bootstrap_undervoltage_fault |=> !d0.switch_enable
        && d0.high_side_force_off && d0.low_side_force_on
        && !d0.low_side_force_off)
        else $error("bootstrap pattern wrong");
    a_short_runs: assert property (
        on0 && !trip0 && !s0.input_uvlo
        && !s0.bootstrap_undervoltage_fault && diag[0]
        |=> d0.switch_enable)
        else $error("short stopped switching");
    a_flag_tracks: assert property (
        1 |=> channel_fault_flag_n_oe == $past(diag))
        else $error("flag enable wrong");
    a_flag_data: assert property (
        channel_fault_flag_n_out == 2'h0)
        else $error("flag data not low");
    a_diag_copy: assert property (
        1 |=> input_dropout_diag == $past(
        {channel_sense[1].input_dropout, s0.input_dropout})
        && analog_bias_undervoltage_diag == $past(analog_bias_undervoltage))
        else $error("diagnostic copy wrong");
    a_amp_dropout: assert property (
        1 |=> d0.error_amp_enable == !$past(s0.input_dropout))
        else $error("amp enable wrong");
endmodule

bind lfs_fault_supervisor lfs_fault_supervisor_monitor #(
    .RESTART_CYCLES(RESTART_CYCLES)
) u_monitor (
    .sys_clk                       (sys_clk),
    .rst                           (rst),
    .channel_sense                 (channel_sense),
    .analog_bias_undervoltage      (analog_bias_undervoltage),
    .channel_drive                 (channel_drive),
    .channel_fault_flag_n_out      (channel_fault_flag_n_out),
    .channel_fault_flag_n_oe       (channel_fault_flag_n_oe),
    .input_dropout_diag            (input_dropout_diag),
    .analog_bias_undervoltage_diag (analog_bias_undervoltage_diag)
);

/* File: sim/lfs_host_model.sv */
/* Host side of the two fault flags: pull-up resistors on the pins.
   Assumes the supervisor's open-drain data and enable outputs. */
module lfs_host_model (
    input  wire logic [1:0] flag_out,
    input  wire logic [1:0] flag_oe,
    output logic [1:0]      flag_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin idles high through its resistor unless the device pulls it.
    assign flag_pin_n[0] = flag_oe[0] ? flag_out[0] : 1'b1;
    assign flag_pin_n[1] = flag_oe[1] ? flag_out[1] : 1'b1;
endmodule
